// ==== design/rpsc_rst_gen.sv ====
// Internal reset generator with stretched release
`timescale 1ns/100ps
`default_nettype none
module rpsc_rst_gen (
  input  wire logic core_clk,
  input  wire logic rstn,
  output var  logic int_rstn
);
  logic       s1_reg;
  logic       s2_reg;
  logic [7:0] hold_reg;

  // Release synchroniser
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
    end else begin
      s1_reg <= 1'b1;
      s2_reg <= s1_reg;
    end
  end

  // Hold after release, restart on any ripple
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hold_reg <= 8'h00;
      int_rstn <= 1'b0;
    end else if (!s2_reg) begin
      hold_reg <= 8'h00;
      int_rstn <= 1'b0;
    end else if (hold_reg != rpsc_pkg::RST_HOLD_CYC) begin
      hold_reg <= hold_reg + 8'h01;
      int_rstn <= 1'b0;
    end else begin
      int_rstn <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== design/rpsc_top.sv ====
// Repeater port supervisor: partition, link test, polarity, fragments
`timescale 1ns/100ps
`default_nettype none
module rpsc_top #(
  parameter logic [rpsc_pkg::CNT_W-1:0] PART_CYC   = rpsc_pkg::PART_CYC,
  parameter logic [rpsc_pkg::CNT_W-1:0] RECON_CYC  = rpsc_pkg::RECON_CYC,
  parameter logic [rpsc_pkg::CNT_W-1:0] LTX_CYC    = rpsc_pkg::LTX_CYC,
  parameter logic [rpsc_pkg::CNT_W-1:0] LRX_CYC    = rpsc_pkg::LRX_CYC,
  parameter logic [rpsc_pkg::CNT_W-1:0] LP_GAP_CYC = rpsc_pkg::LP_GAP_CYC
) (
  input  wire logic                        core_clk,
  input  wire logic                        rstn,
  input  wire logic [rpsc_pkg::AW-1:0]     avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  output var  logic [31:0]                 avs_readdata,
  output var  logic                        avs_waitrequest,
  input  wire logic [rpsc_pkg::NP-1:0]     rx_active,
  input  wire logic [rpsc_pkg::NP-1:0]     tx_active,
  input  wire logic                        sqe_active,
  input  wire logic [rpsc_pkg::NTP-1:0]    link_pulse_rx,
  input  wire logic [rpsc_pkg::NTP-1:0]    rx_pol_reversed,
  input  wire logic                        rep_active,
  output var  logic [rpsc_pkg::NP-1:0]     port_rx_gate,
  output var  logic [rpsc_pkg::NP-1:0]     port_tx_gate,
  output logic      [rpsc_pkg::NTP-1:0]    link_pulse_tx,
  output logic      [rpsc_pkg::NTP-1:0]    pol_correct,
  output var  logic                        jam_extend
);
  localparam int NP  = rpsc_pkg::NP;
  localparam int NTP = rpsc_pkg::NTP;
  localparam int CW  = rpsc_pkg::CNT_W;
  localparam int SW  = NP + 1 + 2 * NTP;

  logic            int_rstn;
  logic [SW-1:0]   s1_reg;
  logic [SW-1:0]   s2_reg;
  logic [SW-1:0]   s3_reg;
  logic [SW-1:0]   lvl_reg;
  logic [NP-1:0]   rx_lvl;
  logic            sqe_lvl;
  logic [NTP-1:0]  lp_lvl;
  logic [NTP-1:0]  pol_lvl;
  logic [NTP-1:0]  lp_d_reg;
  logic [NTP-1:0]  lp_edge;
  logic [1:0]      ctrl_reg;
  logic [NP-1:0]   port_en_reg;
  logic [NTP-1:0]  ltest_en_reg;
  logic [NTP-1:0]  pol_en_reg;
  logic [NP-1:0]   part_w;
  logic [NP-1:0]   lf_w;
  logic [NTP-1:0]  pol_w;
  logic [CW-1:0]   frag_cnt_reg;
  logic            rep_d_reg;

  rpsc_rst_gen u_rst (
    .core_clk (core_clk),
    .rstn     (rstn),
    .int_rstn (int_rstn)
  );

  // Pin synchronisers, level accepted when stages two and three agree
  always_ff @(posedge core_clk or negedge int_rstn) begin
    if (!int_rstn) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      lvl_reg <= '0;
    end else begin
      s1_reg <= {rx_pol_reversed, link_pulse_rx, sqe_active, rx_active};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int k = 0; k < SW; k++) begin
        if (s2_reg[k] == s3_reg[k]) begin
          lvl_reg[k] <= s3_reg[k];
        end
      end
    end
  end

  assign rx_lvl  = lvl_reg[NP-1:0];
  assign sqe_lvl = lvl_reg[NP];
  assign lp_lvl  = lvl_reg[NP+NTP:NP+1];
  assign pol_lvl = lvl_reg[SW-1:NP+NTP+1];

  // Link pulse edge
  always_ff @(posedge core_clk or negedge int_rstn) begin
    if (!int_rstn) begin
      lp_d_reg <= '0;
    end else begin
      lp_d_reg <= lp_lvl;
    end
  end
  assign lp_edge = lp_lvl & ~lp_d_reg;

  // Register read decode
  function automatic logic [31:0] rd_mux(input logic [rpsc_pkg::AW-1:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      rpsc_pkg::CTRL_OFS:      d[1:0] = ctrl_reg;
      rpsc_pkg::PORT_EN_OFS:   d[NP-1:0] = port_en_reg;
      rpsc_pkg::LTEST_EN_OFS:  d[NTP-1:0] = ltest_en_reg;
      rpsc_pkg::POL_EN_OFS:    d[NTP-1:0] = pol_en_reg;
      rpsc_pkg::PART_STAT_OFS: d[NP-1:0] = part_w;
      rpsc_pkg::LINK_STAT_OFS: begin
        d[NTP-1:0] = lf_w[NTP-1:0];
        d[rpsc_pkg::POL_STAT_LSB +: NTP] = pol_w;
      end
      default:                 d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  // Avalon slave: one wait cycle, write lands when waitrequest is low
  always_ff @(posedge core_clk or negedge int_rstn) begin
    if (!int_rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= avs_read ? rd_mux(avs_address) : 32'h0000_0000;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Control registers
  always_ff @(posedge core_clk or negedge int_rstn) begin
    if (!int_rstn) begin
      ctrl_reg     <= rpsc_pkg::CTRL_RST;
      port_en_reg  <= rpsc_pkg::PORT_EN_RST;
      ltest_en_reg <= rpsc_pkg::LTEST_RST;
      pol_en_reg   <= rpsc_pkg::POL_EN_RST;
    end else if (avs_write && !avs_waitrequest) begin
      unique case (avs_address)
        rpsc_pkg::CTRL_OFS:     ctrl_reg <= avs_writedata[1:0];
        rpsc_pkg::PORT_EN_OFS:  port_en_reg <= avs_writedata[NP-1:0];
        rpsc_pkg::LTEST_EN_OFS: ltest_en_reg <= avs_writedata[NTP-1:0];
        rpsc_pkg::POL_EN_OFS:   pol_en_reg <= avs_writedata[NTP-1:0];
        default:                ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // Fragment extension
  always_ff @(posedge core_clk or negedge int_rstn) begin
    if (!int_rstn) begin
      frag_cnt_reg <= '0;
      rep_d_reg    <= 1'b0;
      jam_extend   <= 1'b0;
    end else begin
      rep_d_reg <= rep_active;
      if (rep_active && !rep_d_reg) begin
        frag_cnt_reg <= CW'(1);
        jam_extend   <= 1'b0;
      end else if (rep_active || jam_extend) begin
        if (frag_cnt_reg != rpsc_pkg::FRAG_CYC) begin
          frag_cnt_reg <= frag_cnt_reg + CW'(1);
        end else begin
          jam_extend <= 1'b0;
        end
      end
      if (!rep_active && rep_d_reg && frag_cnt_reg < rpsc_pkg::FRAG_CYC) begin
        jam_extend <= 1'b1;
      end
    end
  end

  // Per-port supervision
  for (genvar i = 0; i < NP; i++) begin : g_port
    rpsc_pkg::rpsc_part_e st_reg;
    logic          coll;
    logic          alt;
    logic          act;
    logic          act_end;
    logic          act_d_reg;
    logic          tx_d_reg;
    logic          att_coll_reg;
    logic          len_coll_reg;
    logic [5:0]    ncons_reg;
    logic [CW-1:0] ccnt_reg;
    logic [CW-1:0] len_reg;

    if (i == rpsc_pkg::AUI_IDX) begin : g_aui
      assign coll = sqe_lvl;
      assign alt  = ctrl_reg[rpsc_pkg::AUI_ALT_BIT];
    end else begin : g_tpc
      assign coll = tx_active[i] & rx_lvl[i];
      assign alt  = ctrl_reg[rpsc_pkg::TP_ALT_BIT];
    end
    assign act     = tx_active[i] | (rx_lvl[i] & ~alt);
    assign act_end = act_d_reg & ~act;
    assign part_w[i] = (st_reg == rpsc_pkg::RPSC_PART);

    always_ff @(posedge core_clk or negedge int_rstn) begin
      if (!int_rstn) begin
        st_reg       <= rpsc_pkg::RPSC_CONN;
        ccnt_reg     <= '0;
        ncons_reg    <= 6'h00;
        att_coll_reg <= 1'b0;
        tx_d_reg     <= 1'b0;
        act_d_reg    <= 1'b0;
        len_reg      <= '0;
        len_coll_reg <= 1'b0;
      end else begin
        tx_d_reg  <= tx_active[i];
        act_d_reg <= act;
        if (!coll) begin
          ccnt_reg <= '0;
        end else if (ccnt_reg != PART_CYC) begin
          ccnt_reg <= ccnt_reg + CW'(1);
        end
        if (tx_active[i] && !tx_d_reg) begin
          att_coll_reg <= coll;
        end else if (coll) begin
          att_coll_reg <= 1'b1;
        end
        if (st_reg == rpsc_pkg::RPSC_PART) begin
          ncons_reg <= 6'h00;
        end else if (!tx_active[i] && tx_d_reg) begin
          ncons_reg <= att_coll_reg ? ncons_reg + 6'h01 : 6'h00;
        end
        if (act) begin
          if (len_reg != RECON_CYC) begin
            len_reg <= len_reg + CW'(1);
          end
          if (coll) begin
            len_coll_reg <= 1'b1;
          end
        end else begin
          len_reg      <= '0;
          len_coll_reg <= 1'b0;
        end
        unique case (st_reg)
          rpsc_pkg::RPSC_CONN: begin
            if (port_en_reg[i] && (ccnt_reg == PART_CYC ||
                ncons_reg == rpsc_pkg::CONS_COLL)) begin
              st_reg <= rpsc_pkg::RPSC_PART;
            end
          end
          rpsc_pkg::RPSC_PART: begin
            if (act_end && len_reg == RECON_CYC && !len_coll_reg) begin
              st_reg <= rpsc_pkg::RPSC_CONN;
            end
          end
        endcase
      end
    end

    if (i < NTP) begin : g_tp
      logic          lf_reg;
      logic          ltx_reg;
      logic          rx_d_reg;
      logic          pol_done_reg;
      logic          pol_inv_reg;
      logic [2:0]    lpc_reg;
      logic [CW-1:0] itx_reg;
      logic [CW-1:0] irx_reg;
      logic          rx_start;

      assign rx_start         = rx_lvl[i] & ~rx_d_reg;
      assign lf_w[i]          = lf_reg;
      assign pol_w[i]         = pol_inv_reg;
      assign pol_correct[i]   = pol_inv_reg;
      assign link_pulse_tx[i] = ltx_reg;

      // Idle link pulses, independent of port state
      always_ff @(posedge core_clk or negedge int_rstn) begin
        if (!int_rstn) begin
          itx_reg <= '0;
          ltx_reg <= 1'b0;
        end else begin
          ltx_reg <= !tx_active[i] && itx_reg == LTX_CYC;
          if (tx_active[i] || itx_reg == LTX_CYC) begin
            itx_reg <= '0;
          end else begin
            itx_reg <= itx_reg + CW'(1);
          end
        end
      end

      // Receive link monitor
      always_ff @(posedge core_clk or negedge int_rstn) begin
        if (!int_rstn) begin
          lf_reg   <= 1'b1;
          irx_reg  <= '0;
          lpc_reg  <= 3'h0;
          rx_d_reg <= 1'b0;
        end else begin
          rx_d_reg <= rx_lvl[i];
          if (rx_lvl[i] || lp_edge[i]) begin
            irx_reg <= '0;
          end else if (irx_reg != LRX_CYC) begin
            irx_reg <= irx_reg + CW'(1);
          end
          if (rx_start) begin
            lpc_reg <= 3'h0;
          end else if (lp_edge[i] && lpc_reg != rpsc_pkg::LP_LAST) begin
            lpc_reg <= lpc_reg + 3'h1;
          end else if (irx_reg >= LP_GAP_CYC) begin
            lpc_reg <= 3'h0;
          end
          if (!ltest_en_reg[i]) begin
            lf_reg <= 1'b0;
          end else if (lf_reg && (rx_start ||
                       (lp_edge[i] && lpc_reg == rpsc_pkg::LP_LAST))) begin
            lf_reg <= 1'b0;
          end else if (irx_reg == LRX_CYC) begin
            lf_reg <= 1'b1;
          end
        end
      end

      // Polarity, sampled on the first packet after reset or link fail that arrives outside link fail
      always_ff @(posedge core_clk or negedge int_rstn) begin
        if (!int_rstn) begin
          pol_done_reg <= 1'b0;
          pol_inv_reg  <= 1'b0;
        end else if (!pol_en_reg[i]) begin
          pol_done_reg <= 1'b0;
          pol_inv_reg  <= 1'b0;
        end else if (lf_reg) begin
          pol_done_reg <= 1'b0;
        end else if (rx_start && !pol_done_reg) begin
          pol_done_reg <= 1'b1;
          pol_inv_reg  <= pol_lvl[i];
        end
      end
    end else begin : g_nolink
      assign lf_w[i] = 1'b0;
    end
  end

  // Repeat gates
  always_ff @(posedge core_clk or negedge int_rstn) begin
    if (!int_rstn) begin
      port_rx_gate <= '0;
      port_tx_gate <= '0;
    end else begin
      port_rx_gate <= port_en_reg & ~part_w & ~lf_w;
      port_tx_gate <= port_en_reg & ~lf_w;
    end
  end
endmodule
`default_nettype wire

// ==== pkg/rpsc_pkg.sv ====
// Constants, register map and types for the repeater port supervisor
// What this block does
// - Fragments under 96 bits, preamble included, are padded to 96 bits with jam
// - Partitioned port still gets transmit data, its receive is not repeated
// - Enabled port partitions after 1024 to 2048 bit times of continuous collision
// - Enabled port partitions after 32 consecutive colliding transmit attempts
// - Standard reconnect: collision-free transmit or receive over 512 bit times
// - Alternate reconnect: only collision-free transmit over 512 bit times counts
// - One algorithm choice for all twisted-pair ports, separate for attachment port
// - Each port partitions and reconnects independently of all others
// - Link pulse sent after transmitter idle longer than 8 to 17 ms
// - No packets or pulses for 65 to 132 ms with test enabled: link fail
// - Link fail disables repeat both ways until four pulses or one packet
// - Per-port link test receive disable; disabled port never enters link fail
// - Link pulses always sent, whatever the port state
// - Per-port polarity correction, evaluated once after reset or link fail
// - Block stays in reset 10 crystal cycles after reset release
// - During reset outputs are inactive and transmitters idle
// - After reset: standard algorithm, receivers and link test on, link fail, no polarity
// - Internal reset has a guaranteed width despite a rippling reset edge
// - Bit-time port timing derives from the 20 MHz crystal rate, link pulse timing from the 250 MHz core clock
package rpsc_pkg;
  localparam int NP      = 9;
  localparam int NTP     = 8;
  localparam int AUI_IDX = 8;
  localparam int CNT_W   = 24;

  // Clock rates
  localparam int CLK_MHZ  = 250;
  localparam int XTAL_MHZ = 20;
  localparam int BIT_XTAL = 2;
  localparam int BIT_CYC  = (BIT_XTAL * CLK_MHZ + XTAL_MHZ - 1) / XTAL_MHZ;

  // Bit-time figures
  localparam int FRAG_BITS      = 96;
  localparam int PART_MIN_BITS  = 1024;
  localparam int PART_MAX_BITS  = 2048;
  localparam int RECON_BITS     = 512;
  localparam int CONS_ATTEMPTS  = 32;
  localparam int LP_CONS        = 4;

  // Millisecond figures in microseconds, reset hold in crystal cycles
  localparam int LTX_MIN_US = 8000;
  localparam int LTX_MAX_US = 17000;
  localparam int LRX_MIN_US = 65000;
  localparam int LRX_MAX_US = 132000;
  localparam int RST_HOLD_XTAL = 10;

  localparam logic [CNT_W-1:0] FRAG_CYC  = CNT_W'(FRAG_BITS * BIT_CYC);
  localparam logic [CNT_W-1:0] PART_CYC  = CNT_W'(PART_MIN_BITS * BIT_CYC);
  localparam logic [CNT_W-1:0] RECON_CYC = CNT_W'(RECON_BITS * BIT_CYC);
  localparam logic [CNT_W-1:0] LTX_CYC   = CNT_W'(LTX_MIN_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] LRX_CYC   = CNT_W'(LRX_MIN_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] LP_GAP_CYC = CNT_W'(LTX_MAX_US * CLK_MHZ);
  localparam logic [7:0] RST_HOLD_CYC =
    8'((RST_HOLD_XTAL * CLK_MHZ + XTAL_MHZ - 1) / XTAL_MHZ);
  localparam logic [5:0] CONS_COLL = 6'(CONS_ATTEMPTS);
  localparam logic [2:0] LP_LAST   = 3'(LP_CONS - 1);

  // Register map, byte addresses
  localparam int AW = 5;
  localparam logic [AW-1:0] CTRL_OFS      = 5'h00;
  localparam logic [AW-1:0] PORT_EN_OFS   = 5'h04;
  localparam logic [AW-1:0] LTEST_EN_OFS  = 5'h08;
  localparam logic [AW-1:0] POL_EN_OFS    = 5'h0C;
  localparam logic [AW-1:0] PART_STAT_OFS = 5'h10;
  localparam logic [AW-1:0] LINK_STAT_OFS = 5'h14;

  // Fields
  localparam int TP_ALT_BIT  = 0;
  localparam int AUI_ALT_BIT = 1;
  localparam int POL_STAT_LSB = 8;

  // Reset values
  localparam logic [1:0]    CTRL_RST     = 2'h0;
  localparam logic [NP-1:0] PORT_EN_RST  = 9'h1FF;
  localparam logic [NTP-1:0] LTEST_RST   = 8'hFF;
  localparam logic [NTP-1:0] POL_EN_RST  = 8'h00;

  typedef enum logic {
    RPSC_CONN = 1'b0,
    RPSC_PART = 1'b1
  } rpsc_part_e;
endpackage

// ==== verification/rpsc_seg_model.sv ====
// Network segment model: carrier, link pulses and polarity per port
`timescale 1ns/100ps
`default_nettype none
module rpsc_seg_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] alive,
  input  wire logic [8:0] pkt,
  input  wire logic [7:0] rev,
  output logic      [8:0] rx_active,
  output logic      [7:0] link_pulse_rx,
  output logic      [7:0] rx_pol_reversed
);
  logic [5:0] tick_reg;
  initial tick_reg = 6'h00;
  always_ff @(posedge core_clk) begin
    tick_reg <= tick_reg + 6'h01;
  end
  // Live segments pulse 4 cycles wide every 64 cycles
  assign link_pulse_rx   = (tick_reg < 6'h04) ? alive : 8'h00;
  assign rx_active       = pkt;
  assign rx_pol_reversed = rev;
endmodule
`default_nettype wire

// ==== verification/rpsc_top_props.sv ====
// Concurrent checks on the repeater port supervisor ports
`timescale 1ns/100ps
`default_nettype none
module rpsc_top_props #(
  parameter logic [rpsc_pkg::CNT_W-1:0] LTX_CYC = rpsc_pkg::LTX_CYC
) (
  input wire logic                     core_clk,
  input wire logic                     rstn,
  input wire logic [rpsc_pkg::AW-1:0]  avs_address,
  input wire logic                     avs_read,
  input wire logic                     avs_write,
  input wire logic [31:0]              avs_readdata,
  input wire logic                     avs_waitrequest,
  input wire logic [rpsc_pkg::NP-1:0]  tx_active,
  input wire logic                     rep_active,
  input wire logic [rpsc_pkg::NP-1:0]  port_rx_gate,
  input wire logic [rpsc_pkg::NP-1:0]  port_tx_gate,
  input wire logic [rpsc_pkg::NTP-1:0] link_pulse_tx,
  input wire logic [rpsc_pkg::NTP-1:0] pol_correct,
  input wire logic                     jam_extend
);
  logic [7:0]                 rcnt_reg;
  logic [rpsc_pkg::CNT_W-1:0] idle_reg;
  logic [15:0]                frag_reg;
  logic                       rep_d_reg;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Cycles since reset release
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) rcnt_reg <= 8'h00;
    else if (rcnt_reg != 8'hFF) rcnt_reg <= rcnt_reg + 8'h01;
  end
  // Idle cycles of port 0 transmitter
  always_ff @(posedge core_clk) begin
    if (!rstn || rcnt_reg < 8'd129 || tx_active[0] || link_pulse_tx[0]) idle_reg <= '0;
    else idle_reg <= idle_reg + rpsc_pkg::CNT_W'(1);
  end
  // Cycles since repeat start
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rep_d_reg <= 1'b0;
      frag_reg  <= 16'h0000;
    end else begin
      rep_d_reg <= rep_active;
      if (rep_active && !rep_d_reg) frag_reg <= 16'h0001;
      else if (frag_reg != 16'hFFFF) frag_reg <= frag_reg + 16'h0001;
    end
  end
  chk_wait_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_wait_resp: assert property ((avs_read || avs_write) && avs_waitrequest
    && rcnt_reg > 8'd130 |=> !avs_waitrequest)
    else $error("request not answered in the next cycle");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 5'h14
    |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_gate_order: assert property ((port_rx_gate & ~port_tx_gate) == 9'h000)
    else $error("receive repeated on a port not transmitted to");
  chk_pulse_width: assert property (link_pulse_tx != 8'h00
    |=> (link_pulse_tx & $past(link_pulse_tx)) == 8'h00)
    else $error("link pulse longer than one cycle");
  chk_pulse_late: assert property (link_pulse_tx[0] |-> idle_reg >= LTX_CYC - 2)
    else $error("link pulse before idle window");
  chk_pulse_due: assert property (idle_reg <= LTX_CYC + 3)
    else $error("link pulse missing after idle window");
  chk_reset_hold: assert property (rcnt_reg < 8'd125 |-> avs_waitrequest
    && port_rx_gate == 9'h000 && port_tx_gate == 9'h000 && link_pulse_tx == 8'h00
    && pol_correct == 8'h00 && !jam_extend)
    else $error("outputs active during reset hold");
  chk_reset_dflt: assert property (rcnt_reg == 8'd130 |-> port_rx_gate == 9'h100
    && port_tx_gate == 9'h100 && pol_correct == 8'h00)
    else $error("port state after reset wrong");
  chk_jam_start: assert property ($fell(rep_active) && frag_reg < 16'd2300
    |-> ##[1:3] jam_extend)
    else $error("short fragment not extended");
  chk_jam_end: assert property (jam_extend |-> frag_reg <= 16'd2403)
    else $error("jam beyond 96 bit times");
endmodule
bind rpsc_top rpsc_top_props #(.LTX_CYC(LTX_CYC)) u_props (
  .core_clk(core_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .tx_active(tx_active), .rep_active(rep_active), .port_rx_gate(port_rx_gate),
  .port_tx_gate(port_tx_gate), .link_pulse_tx(link_pulse_tx), .pol_correct(pol_correct),
  .jam_extend(jam_extend));
`default_nettype wire

// ==== verification/rpsc_top_tb.sv ====
// Self-checking testbench for the repeater port supervisor
`timescale 1ns/100ps
`default_nettype none
module rpsc_top_tb;
  logic        core_clk;
  logic        rstn;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [8:0]  rx_active;
  logic [8:0]  tx_active;
  logic        sqe_active;
  logic [7:0]  link_pulse_rx;
  logic [7:0]  rx_pol_reversed;
  logic        rep_active;
  logic [8:0]  port_rx_gate;
  logic [8:0]  port_tx_gate;
  logic [7:0]  link_pulse_tx;
  logic [7:0]  pol_correct;
  logic        jam_extend;
  logic [7:0]  alive;
  logic [8:0]  pkt;
  logic [7:0]  rev;
  logic [31:0] rdat;
  int          error_cnt;
  int          checked;
  rpsc_top #(.PART_CYC(24'd40), .RECON_CYC(24'd20), .LTX_CYC(24'd50), .LRX_CYC(24'd300),
    .LP_GAP_CYC(24'd80)) uut (
    .core_clk(core_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_active(rx_active), .tx_active(tx_active),
    .sqe_active(sqe_active), .link_pulse_rx(link_pulse_rx),
    .rx_pol_reversed(rx_pol_reversed), .rep_active(rep_active),
    .port_rx_gate(port_rx_gate), .port_tx_gate(port_tx_gate),
    .link_pulse_tx(link_pulse_tx), .pol_correct(pol_correct), .jam_extend(jam_extend));
  rpsc_seg_model seg (.core_clk(core_clk), .alive(alive), .pkt(pkt), .rev(rev),
    .rx_active(rx_active), .link_pulse_rx(link_pulse_rx), .rx_pol_reversed(rx_pol_reversed));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic results;
    $display("Comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Avalon transfer, held until waitrequest sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 400);
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 400) begin
      error_cnt++;
      results();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input string nm, input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, e, rdat);
  endtask
  task automatic t_reset;
    rd("ctrl", 5'h00, 32'h0000_0000);
    rd("port_en", 5'h04, 32'h0000_01FF);
    rd("ltest_en", 5'h08, 32'h0000_00FF);
    rd("pol_en", 5'h0C, 32'h0000_0000);
    rd("link_stat", 5'h14, 32'h0000_00FF);
    wr(5'h10, 32'h0000_01FF);
    rd("part_stat", 5'h10, 32'h0000_0000);
    rd("unmapped", 5'h1C, 32'h0000_0000);
  endtask
  task automatic t_link;
    alive <= 8'h0F;
    cyc(400);
    chk("rx_gate up", 32'h0000_010F, 32'(port_rx_gate));
    alive <= 8'h07;
    cyc(500);
    chk("tx_gate fail", 32'h0000_0107, 32'(port_tx_gate));
    wr(5'h08, 32'h0000_00F7);
    cyc(400);
    chk("ltest off", 32'h0000_010F, 32'(port_rx_gate));
  endtask
  task automatic t_lptx;
    int n;
    n = 0;
    repeat (510) begin
      @(posedge core_clk);
      if (link_pulse_tx[5] === 1'b1) n++;
    end
    chk("pulses idle", 32'd10, 32'(n));
    n = 0;
    tx_active[5] <= 1'b1;
    cyc(1);
    repeat (200) begin
      @(posedge core_clk);
      if (link_pulse_tx[5] === 1'b1) n++;
    end
    tx_active[5] <= 1'b0;
    chk("pulses busy", 32'd0, 32'(n));
  endtask
  task automatic coll(input int p, input int n);
    tx_active[p] <= 1'b1;
    pkt[p]       <= 1'b1;
    cyc(n);
    tx_active[p] <= 1'b0;
    pkt[p]       <= 1'b0;
    cyc(10);
  endtask
  task automatic t_part;
    coll(0, 25);
    rd("part short", 5'h10, 32'h0000_0000);
    coll(0, 80);
    rd("part long", 5'h10, 32'h0000_0001);
    chk("rx gate part", 32'h0000_0000, 32'(port_rx_gate[0]));
    chk("tx gate part", 32'h0000_0001, 32'(port_tx_gate[0]));
    wr(5'h00, 32'h0000_0001);
    pkt[0] <= 1'b1;
    cyc(40);
    pkt[0] <= 1'b0;
    cyc(10);
    rd("alt rx", 5'h10, 32'h0000_0001);
    tx_active[0] <= 1'b1;
    cyc(40);
    tx_active[0] <= 1'b0;
    cyc(10);
    rd("alt tx", 5'h10, 32'h0000_0000);
  endtask
  task automatic t_att;
    wr(5'h00, 32'h0000_0002);
    for (int i = 0; i < 32; i++) begin
      if (i == 31) rd("att 31", 5'h10, 32'h0000_0000);
      coll(1, 8);
    end
    rd("att 32", 5'h10, 32'h0000_0002);
    pkt[1] <= 1'b1;
    cyc(40);
    pkt[1] <= 1'b0;
    cyc(10);
    rd("std rx", 5'h10, 32'h0000_0000);
    sqe_active <= 1'b1;
    cyc(60);
    sqe_active <= 1'b0;
    pkt[8]     <= 1'b1;
    cyc(40);
    pkt[8] <= 1'b0;
    cyc(10);
    rd("aui alt", 5'h10, 32'h0000_0100);
  endtask
  task automatic t_frag;
    int t;
    rep_active <= 1'b1;
    cyc(100);
    rep_active <= 1'b0;
    cyc(4);
    chk("jam on", 32'h0000_0001, 32'(jam_extend));
    t = 104;
    while (jam_extend === 1'b1 && t < 3000) begin
      @(posedge core_clk);
      t++;
    end
    chk("jam len", 32'h0000_0001, 32'(t >= 2398 && t <= 2404));
    rep_active <= 1'b1;
    cyc(2500);
    rep_active <= 1'b0;
    cyc(4);
    chk("jam long", 32'h0000_0000, 32'(jam_extend));
  endtask
  task automatic t_pol;
    rev[4] <= 1'b1;
    wr(5'h0C, 32'h0000_0010);
    // First packet ends link fail, second is sampled
    repeat (2) begin
      pkt[4] <= 1'b1;
      cyc(40);
      pkt[4] <= 1'b0;
      cyc(10);
    end
    chk("pol on", 32'h0000_0010, 32'(pol_correct));
    wr(5'h0C, 32'h0000_0000);
    cyc(4);
    chk("pol off", 32'h0000_0000, 32'(pol_correct));
  endtask
  task automatic t_rst;
    rstn <= 1'b0;
    cyc(1000);
    chk("rst gates", 32'h0000_0000, 32'({port_rx_gate, port_tx_gate}));
    chk("rst misc", 32'h0002_0000,
      32'({avs_waitrequest, jam_extend, link_pulse_tx, pol_correct}));
    rstn <= 1'b1;
    cyc(40);
    rstn <= 1'b0;
    cyc(2);
    rstn <= 1'b1;
    cyc(120);
    chk("rst hold", 32'h0000_0000, 32'(port_rx_gate));
    cyc(15);
    chk("rst dflt", 32'h0000_0100, 32'(port_rx_gate));
    rd("ctrl rst", 5'h00, 32'h0000_0000);
  endtask
  initial begin
    error_cnt       = 0;
    checked         = 0;
    rstn            = 1'b0;
    avs_address     = 5'h00;
    avs_read        = 1'b0;
    avs_write       = 1'b0;
    avs_writedata   = 32'h0000_0000;
    tx_active       = 9'h000;
    sqe_active      = 1'b0;
    rep_active      = 1'b0;
    alive           = 8'h00;
    pkt             = 9'h000;
    rev             = 8'h00;
    cyc(3);
    rstn <= 1'b1;
    t_reset();
    t_link();
    t_lptx();
    t_part();
    t_att();
    t_frag();
    t_pol();
    t_rst();
    results();
  end
endmodule
`default_nettype wire
